// *** slp_consts.svh ***
// timing counts, command codes and field constants of the supply line link
// Operation
// - zero: no mid edge; one: mid edge
// - sensor times supply bits from sync bit
// - reply bit period set by acknowledge bit
// - sync, command, parity, address, parity
// - write adds data and parity; zero ack
// - read reply: ack, data, parity
// - erase/program ack, then delayed pulse
// - programming pulse lasts nominal 100 ms
// - deactivate grounds outputs; activate pulse selects
// - activate pulse lasts nominal 0.1 ms
// - lock: write bit, erase, then program
// - stored lock acts after next power-on
// - store: erase code 5, program 4
// - dummy read precedes lock sequence
// - pulse voltage measured as 12-bit code
// - status flag set when voltage off-limits
// - codes 2,3,4,5,7: read, write, program, erase, lock
// - header parity one on odd zero count
// - data parity one on even zero count
`ifndef SLP_CONSTS_SVH
`define SLP_CONSTS_SVH
`define SLP_CLK_MHZ        40
`define SLP_SUPPLY_BIT_US  1750
`define SLP_SUPPLY_BIT_CYC (`SLP_SUPPLY_BIT_US * `SLP_CLK_MHZ)
`define SLP_SUPPLY_MAX_US  1800
`define SLP_SYNC_MAX_CYC   (2 * `SLP_SUPPLY_MAX_US * `SLP_CLK_MHZ)
`define SLP_OUTPUT_BIT_US  3000
`define SLP_OUTPUT_BIT_CYC (`SLP_OUTPUT_BIT_US * `SLP_CLK_MHZ)
`define SLP_OUTPUT_MAX_US  4000
`define SLP_ACK_TMO_CYC    (2 * `SLP_OUTPUT_MAX_US * `SLP_CLK_MHZ)
`define SLP_ONE_EDGE_PCT   65
`define SLP_WAIT_US        700
`define SLP_WAIT_CYC       (`SLP_WAIT_US * `SLP_CLK_MHZ)
`define SLP_PROG_US        100000
`define SLP_PROG_CYC       (`SLP_PROG_US * `SLP_CLK_MHZ)
`define SLP_ACT_US         100
`define SLP_ACT_CYC        (`SLP_ACT_US * `SLP_CLK_MHZ)
`define SLP_CMD_READ       3'h2
`define SLP_CMD_WRITE      3'h3
`define SLP_CMD_PROG       3'h4
`define SLP_CMD_ERASE      3'h5
`define SLP_CMD_LOCK       3'h7
`define SLP_ADDR_LOCK      4'h6
`define SLP_ADDR_DEACT     4'hF
`define SLP_BITS_SHORT     5'h0A
`define SLP_BITS_WRITE     5'h19
`define SLP_BITS_READ_ACK  5'h10
`define SLP_IDLE_LVL       1'b1
`define SLP_ADC_LO         12'hD4E
`define SLP_ADC_HI         12'hD84
`endif

// *** slp_pkg.sv ***
// field types and parity functions of the supply line link
package slp_pkg;
	typedef logic [2:0]  slp_cmd_type;
	typedef logic [3:0]  slp_addr_type;
	typedef logic [13:0] slp_data_type;

	function automatic logic slp_cmd_par(input slp_cmd_type c);
		return ^(~c);
	endfunction : slp_cmd_par

	function automatic logic slp_addr_par(input slp_addr_type a);
		return ^(~a);
	endfunction : slp_addr_par

	function automatic logic slp_data_par(input slp_data_type d);
		return ~^(~d);
	endfunction : slp_data_par
endpackage : slp_pkg

// *** slp_link_if.sv ***
// supply line and sensor output pin between programmer and sensor
`timescale 1ns/1ps
interface slp_link_if;
	logic supply_lvl;
	logic prog_lvl;
	logic dev_out_o;
	logic dev_out_oe;
	logic pgm_out_o;
	logic pgm_out_oe;
	logic out_lvl;

	// output pin with pulldown; programmer drive wins
	assign out_lvl = pgm_out_oe ? pgm_out_o : (dev_out_oe ? dev_out_o : 1'b0);

	modport dev (input supply_lvl, input prog_lvl, input out_lvl,
		output dev_out_o, output dev_out_oe);
	modport pgm (output supply_lvl, output prog_lvl, output pgm_out_o,
		output pgm_out_oe, input out_lvl);
endinterface : slp_link_if

// *** slp_sensor.sv ***
// sensor end: decodes supply line telegrams, replies on the output pin
`timescale 1ns/1ps
`include "slp_consts.svh"
module slp_sensor
	import slp_pkg::*;
#(
	parameter int OUT_CYC  = `SLP_OUTPUT_BIT_CYC,
	parameter int SYNC_MAX = `SLP_SYNC_MAX_CYC
)
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// link
	slp_link_if.dev   link,
	// user side
	input  wire logic nv_wipe,
	output logic      selected,
	output logic      lock_applied,
	output logic      cmd_done
);
	typedef enum logic [2:0] {S_IDLE, S_SYNC, S_BITS, S_EXEC, S_REPLY} slp_dstate_type;
	localparam int ONE_OUT = OUT_CYC * `SLP_ONE_EDGE_PCT / 100;

	slp_dstate_type state;
	logic [23:0]    cnt;
	logic [23:0]    per;
	logic [4:0]     nbit;
	logic [23:0]    sh;
	logic           mid;
	logic           sup_q;
	logic [15:0]    tx_sh;
	logic [4:0]     tx_len;
	logic           out_r;
	logic           act_hi;
	logic           pend;
	slp_cmd_type    pend_cmd;
	logic           prog_q;
	logic           cap_done;
	slp_data_type   regs [16];
	slp_data_type   nv [16];

	wire logic         sup_edge = link.supply_lvl ^ sup_q;
	wire logic         late     = cnt >= per - (per >> 3);
	wire logic         long_t   = nbit == `SLP_BITS_WRITE - 5'h01;
	wire logic [8:0]   hdr      = long_t ? sh[23:15] : sh[8:0];
	wire slp_cmd_type  h_cmd    = hdr[8:6];
	wire slp_addr_type h_addr   = hdr[4:1];
	wire slp_data_type h_data   = sh[14:1];
	wire logic         is_wr    = h_cmd == `SLP_CMD_WRITE;
	wire logic         is_rd    = h_cmd == `SLP_CMD_READ;
	wire logic         deact    = is_wr && h_addr == `SLP_ADDR_DEACT;
	wire logic         known    = is_rd || is_wr || h_cmd == `SLP_CMD_PROG
		|| h_cmd == `SLP_CMD_ERASE || h_cmd == `SLP_CMD_LOCK;
	wire logic         par_ok   = hdr[5] == slp_cmd_par(h_cmd)
		&& hdr[0] == slp_addr_par(h_addr)
		&& (!is_wr || sh[0] == slp_data_par(h_data));
	// locked part still answers reads
	wire logic         acc      = state == S_EXEC && known && par_ok
		&& (selected || deact) && (is_rd || !lock_applied);
	wire logic         nv_fire  = pend && prog_q && !link.prog_lvl;
	wire logic         bit_done = state == S_BITS && sup_edge && late;
	wire logic         tx_end   = state == S_REPLY && cnt == 24'(OUT_CYC - 1);

	assign link.dev_out_o  = out_r;
	assign link.dev_out_oe = selected;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			cnt   <= 24'h000000;
			per   <= 24'h000000;
			nbit  <= 5'h00;
		end
		else
		begin
			cnt <= cnt + 24'h000001;
			case (state)
			S_IDLE:
			begin
				cnt <= 24'h000000;
				if (sup_edge)
					state <= S_SYNC;
			end
			S_SYNC:
				if (sup_edge)
				begin
					per   <= cnt + 24'h000001;
					cnt   <= 24'h000000;
					nbit  <= 5'h00;
					state <= S_BITS;
				end
				else if (cnt == 24'(SYNC_MAX))
					state <= S_IDLE;
			S_BITS:
				if (bit_done)
				begin
					cnt  <= 24'h000000;
					nbit <= nbit + 5'h01;
					// header ends after nine bits unless it is a write
					if ((nbit == `SLP_BITS_SHORT - 5'h02 && sh[7:5] != `SLP_CMD_WRITE)
						|| nbit == `SLP_BITS_WRITE - 5'h02)
						state <= S_EXEC;
				end
				else if (cnt == {per[22:0], 1'b0})
					state <= S_IDLE;
			S_EXEC:
			begin
				cnt  <= 24'h000000;
				nbit <= 5'h00;
				state <= (acc && !deact) ? S_REPLY : S_IDLE;
			end
			S_REPLY:
				if (tx_end)
				begin
					cnt  <= 24'h000000;
					nbit <= nbit + 5'h01;
					if (nbit == tx_len - 5'h01)
						state <= S_IDLE;
				end
			default:
				state <= S_IDLE;
			endcase
		end
	end

	// telegram bit capture
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sup_q <= `SLP_IDLE_LVL;
			sh    <= 24'h000000;
			mid   <= 1'b0;
		end
		else
		begin
			sup_q <= link.supply_lvl;
			if (state == S_SYNC)
				mid <= 1'b0;
			else if (state == S_BITS && sup_edge)
			begin
				if (!late)
					mid <= 1'b1;
				else
				begin
					sh  <= {sh[22:0], mid};
					mid <= 1'b0;
				end
			end
		end
	end

	// reply on the output pin
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_r  <= `SLP_IDLE_LVL;
			tx_sh  <= 16'h0000;
			tx_len <= 5'h00;
		end
		else if (acc && !deact)
		begin
			out_r  <= ~out_r;
			tx_sh  <= is_rd ? {1'b0, regs[h_addr], slp_data_par(regs[h_addr])}
				: 16'h0000;
			tx_len <= is_rd ? `SLP_BITS_READ_ACK : 5'h01;
		end
		else if (tx_end)
		begin
			out_r <= ~out_r;
			tx_sh <= {tx_sh[14:0], 1'b0};
		end
		else if (state == S_REPLY && cnt == 24'(ONE_OUT - 1) && tx_sh[15])
			out_r <= ~out_r;
	end

	// selection, pending store and lock capture
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			selected     <= 1'b1;
			act_hi       <= 1'b0;
			pend         <= 1'b0;
			pend_cmd     <= `SLP_CMD_READ;
			prog_q       <= 1'b0;
			cap_done     <= 1'b0;
			lock_applied <= 1'b0;
			cmd_done     <= 1'b0;
		end
		else
		begin
			prog_q   <= link.prog_lvl;
			cmd_done <= acc;
			act_hi   <= !selected && link.out_lvl;
			if (acc && deact)
				selected <= 1'b0;
			else if (act_hi && !link.out_lvl)
				selected <= 1'b1;
			if (acc && !is_rd && !is_wr)
			begin
				pend     <= 1'b1;
				pend_cmd <= h_cmd;
			end
			else if (nv_fire)
				pend <= 1'b0;
			if (!cap_done)
			begin
				cap_done     <= 1'b1;
				lock_applied <= nv[`SLP_ADDR_LOCK][0];
			end
		end
	end

	for (genvar i = 0; i < 16; i++)
	begin : g_reg
		always_ff @(posedge clk_sys)
		begin
			if (nv_wipe || (nv_fire && pend_cmd == `SLP_CMD_ERASE))
				nv[i] <= 14'h0000;
			else if (nv_fire && pend_cmd == `SLP_CMD_PROG)
				nv[i] <= regs[i];
			else if (nv_fire && pend_cmd == `SLP_CMD_LOCK && 4'(i) == `SLP_ADDR_LOCK)
				nv[i] <= 14'h0001;
		end

		always_ff @(posedge clk_sys)
		begin
			if (!cap_done)
				regs[i] <= nv[i];
			else if (acc && is_wr && !deact && h_addr == 4'(i))
				regs[i] <= h_data;
		end
	end
endmodule : slp_sensor

// *** slp_programmer.sv ***
// programmer end: sends telegrams on the supply line, reads replies
`timescale 1ns/1ps
`include "slp_consts.svh"
module slp_programmer
	import slp_pkg::*;
#(
	parameter int          SUP_CYC  = `SLP_SUPPLY_BIT_CYC,
	parameter int          ACK_TMO  = `SLP_ACK_TMO_CYC,
	parameter int          TW_CYC   = `SLP_WAIT_CYC,
	parameter int          PROG_CYC = `SLP_PROG_CYC,
	parameter logic [11:0] ADC_LO   = `SLP_ADC_LO,
	parameter logic [11:0] ADC_HI   = `SLP_ADC_HI
)
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// link
	slp_link_if.pgm           link,
	// telegram and activate pulse request
	input  wire logic         start,
	input  wire slp_cmd_type  cmd,
	input  wire slp_addr_type addr,
	input  wire slp_data_type wdata,
	input  wire logic         act_start,
	// results
	output logic              busy,
	output logic              done,
	output logic              ack_ok,
	output slp_data_type      rdata,
	output logic              rdata_ok,
	// programming voltage monitor
	input  wire logic [11:0]  adc_code,
	output logic [11:0]       prog_voltage_code,
	output logic              prog_bad
);
	typedef enum logic [2:0] {P_IDLE, P_TX, P_ACKW, P_ACKM, P_RX, P_WAIT, P_PULSE,
		P_ACT} slp_pstate_type;
	localparam int ONE_SUP = SUP_CYC * `SLP_ONE_EDGE_PCT / 100;
	localparam int ACT_CYC = `SLP_ACT_CYC;

	slp_pstate_type state;
	logic [23:0]    cnt;
	logic [23:0]    per;
	logic [4:0]     nbit;
	logic [4:0]     last_bit;
	logic [24:0]    tx_sh;
	logic [13:0]    rx_sh;
	logic           mid;
	logic           out_q;
	logic           busy_q;
	logic           act_drv;
	slp_cmd_type    cmd_r;

	wire logic out_edge = link.out_lvl ^ out_q;
	wire logic late     = cnt >= per - (per >> 3);
	wire logic go       = state == P_IDLE && start;
	wire logic tx_end   = state == P_TX && cnt == 24'(SUP_CYC - 1);
	wire logic ack_tmo  = cnt == 24'(ACK_TMO);
	wire logic rd_cmd   = cmd_r == `SLP_CMD_READ;
	// erase, program and lock all take a programming pulse
	wire logic pulse_cmd = cmd_r == `SLP_CMD_ERASE || cmd_r == `SLP_CMD_PROG
		|| cmd_r == `SLP_CMD_LOCK;
	wire logic rx_last  = state == P_RX && out_edge && late
		&& nbit == `SLP_BITS_READ_ACK - 5'h02;
	wire logic adc_pt   = state == P_PULSE && cnt == 24'(PROG_CYC / 2);

	assign busy            = state != P_IDLE;
	assign done            = busy_q && !busy;
	assign link.pgm_out_o  = act_drv;
	assign link.pgm_out_oe = act_drv;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= P_IDLE;
			cnt   <= 24'h000000;
			per   <= 24'h000000;
			nbit  <= 5'h00;
		end
		else
		begin
			cnt <= cnt + 24'h000001;
			case (state)
			P_IDLE:
			begin
				cnt  <= 24'h000000;
				nbit <= 5'h00;
				if (start)
					state <= P_TX;
				else if (act_start)
					state <= P_ACT;
			end
			P_TX:
				if (tx_end)
				begin
					cnt  <= 24'h000000;
					nbit <= nbit + 5'h01;
					if (nbit == last_bit)
						state <= P_ACKW;
				end
			P_ACKW:
				if (out_edge)
				begin
					cnt   <= 24'h000000;
					state <= P_ACKM;
				end
				else if (ack_tmo)
					state <= P_IDLE;
			P_ACKM:
				if (out_edge)
				begin
					per   <= cnt + 24'h000001;
					cnt   <= 24'h000000;
					nbit  <= 5'h00;
					// read data follows; pulse commands wait before the pulse
					if (rd_cmd)
						state <= P_RX;
					else if (pulse_cmd)
						state <= P_WAIT;
					else
						state <= P_IDLE;
				end
				else if (ack_tmo)
					state <= P_IDLE;
			P_RX:
				if (out_edge && late)
				begin
					cnt  <= 24'h000000;
					nbit <= nbit + 5'h01;
					if (rx_last)
						state <= P_IDLE;
				end
				else if (cnt == {per[22:0], 1'b0})
					state <= P_IDLE;
			P_WAIT:
				if (cnt == 24'(TW_CYC - 1))
				begin
					cnt   <= 24'h000000;
					state <= P_PULSE;
				end
			P_PULSE:
				if (cnt == 24'(PROG_CYC - 1))
					state <= P_IDLE;
			P_ACT:
				if (cnt == 24'(ACT_CYC - 1))
					state <= P_IDLE;
			default:
				state <= P_IDLE;
			endcase
		end
	end

	// supply line modulation
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link.supply_lvl <= `SLP_IDLE_LVL;
			tx_sh           <= 25'h0000000;
			last_bit        <= 5'h00;
			cmd_r           <= `SLP_CMD_READ;
		end
		else if (go)
		begin
			link.supply_lvl <= ~link.supply_lvl;
			tx_sh           <= {1'b0, cmd, slp_cmd_par(cmd), addr, slp_addr_par(addr),
				wdata, slp_data_par(wdata)};
			last_bit        <= (cmd == `SLP_CMD_WRITE ? `SLP_BITS_WRITE
				: `SLP_BITS_SHORT) - 5'h01;
			cmd_r           <= cmd;
		end
		else if (tx_end)
		begin
			link.supply_lvl <= ~link.supply_lvl;
			tx_sh           <= {tx_sh[23:0], 1'b0};
		end
		else if (state == P_TX && cnt == 24'(ONE_SUP - 1) && tx_sh[24])
			link.supply_lvl <= ~link.supply_lvl;
	end

	// reply bit capture
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_q <= `SLP_IDLE_LVL;
			rx_sh <= 14'h0000;
			mid   <= 1'b0;
		end
		else
		begin
			out_q <= link.out_lvl;
			if (state == P_ACKM)
				mid <= 1'b0;
			else if (state == P_RX && out_edge)
			begin
				if (!late)
					mid <= 1'b1;
				else
				begin
					rx_sh <= {rx_sh[12:0], mid};
					mid   <= 1'b0;
				end
			end
		end
	end

	// results of the telegram
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_q   <= 1'b0;
			ack_ok   <= 1'b0;
			rdata    <= 14'h0000;
			rdata_ok <= 1'b0;
		end
		else
		begin
			busy_q <= busy;
			if (go)
			begin
				ack_ok   <= 1'b0;
				rdata_ok <= 1'b0;
			end
			else if (state == P_ACKM && out_edge)
				ack_ok <= 1'b1;
			else if (rx_last)
			begin
				rdata    <= rx_sh;
				rdata_ok <= mid == slp_data_par(rx_sh);
			end
		end
	end

	// programming pulse, its voltage check and the activate pulse
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link.prog_lvl     <= 1'b0;
			prog_voltage_code <= 12'h000;
			prog_bad          <= 1'b0;
			act_drv           <= 1'b0;
		end
		else
		begin
			link.prog_lvl <= (state == P_WAIT && cnt == 24'(TW_CYC - 1))
				|| (state == P_PULSE && cnt != 24'(PROG_CYC - 1));
			act_drv       <= (state == P_IDLE && act_start && !start)
				|| (state == P_ACT && cnt != 24'(ACT_CYC - 1));
			if (adc_pt)
			begin
				prog_voltage_code <= adc_code;
				prog_bad          <= adc_code < ADC_LO || adc_code > ADC_HI;
			end
		end
	end
endmodule : slp_programmer

// *** slp_link_assertions.sv ***
// concurrent checks on the link between programmer and sensor
`timescale 1ns/1ps
`include "slp_consts.svh"
module slp_link_assertions
#(
	parameter int SUP_CYC  = `SLP_SUPPLY_BIT_CYC,
	parameter int OUT_CYC  = `SLP_OUTPUT_BIT_CYC,
	parameter int TW_CYC   = `SLP_WAIT_CYC,
	parameter int PROG_CYC = `SLP_PROG_CYC
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// link signals
	input wire logic supply_lvl,
	input wire logic prog_lvl,
	input wire logic dev_out_o,
	input wire logic dev_out_oe,
	input wire logic pgm_out_o,
	input wire logic pgm_out_oe,
	input wire logic out_lvl
);
	localparam int ACT_MIN = 2000;
	localparam int ACT_MAX = 8000;
	logic        sup_prev;
	logic        out_prev;
	logic        sup_chg;
	logic        out_chg;
	int unsigned sup_cnt;
	int unsigned out_cnt;
	int unsigned act_cnt;
	int unsigned prog_cnt;

	assign sup_chg = supply_lvl != sup_prev;
	assign out_chg = out_lvl != out_prev;

	// cycles since the last level change on the supply and output lines
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sup_prev <= 1'b1;
			out_prev <= 1'b1;
			sup_cnt  <= 32'h0000FFFF;
			out_cnt  <= 32'h0000FFFF;
		end
		else
		begin
			sup_prev <= supply_lvl;
			out_prev <= out_lvl;
			sup_cnt  <= sup_chg ? 32'h1 : sup_cnt + ((sup_cnt < 32'hFFFF) ? 32'h1 : 32'h0);
			out_cnt  <= out_chg ? 32'h1 : out_cnt + ((out_cnt < 32'hFFFF) ? 32'h1 : 32'h0);
		end
	end

	// pulse lengths
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			act_cnt  <= 32'h0;
			prog_cnt <= 32'h0;
		end
		else
		begin
			act_cnt  <= pgm_out_oe ? act_cnt + 32'h1 : 32'h0;
			prog_cnt <= prog_lvl ? prog_cnt + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_sup_gap;
		sup_chg |-> sup_cnt >= SUP_CYC / 5;
	endproperty
	property p_out_gap;
		out_chg && dev_out_oe && $past(dev_out_oe) && !pgm_out_oe |-> out_cnt >= OUT_CYC / 5;
	endproperty
	property p_reply_after;
		out_chg && dev_out_oe && $past(dev_out_oe) && !pgm_out_oe |-> sup_cnt >= 2;
	endproperty
	property p_act_len;
		$fell(pgm_out_oe) |-> act_cnt >= ACT_MIN && act_cnt <= ACT_MAX;
	endproperty
	property p_act_level;
		pgm_out_oe |-> pgm_out_o && !dev_out_oe;
	endproperty
	property p_reselect;
		$fell(pgm_out_oe) && !dev_out_oe |-> ##[1:4] dev_out_oe;
	endproperty
	property p_prog_len;
		$fell(prog_lvl) |-> prog_cnt >= PROG_CYC * 95 / 100 && prog_cnt <= PROG_CYC * 105 / 100;
	endproperty
	property p_prog_wait;
		$rose(prog_lvl) |-> out_cnt >= TW_CYC * 5 / 7 && out_cnt <= TW_CYC * 10 / 7 + 4;
	endproperty
	property p_prog_hold;
		prog_lvl && $past(prog_lvl) |-> $stable(supply_lvl) && $stable(out_lvl);
	endproperty

	a_sup_gap: assert property (p_sup_gap) else $error("supply edges too close");
	a_out_gap: assert property (p_out_gap) else $error("reply edges too close");
	a_reply_after: assert property (p_reply_after) else $error("reply inside telegram");
	a_act_len: assert property (p_act_len) else $error("activate pulse length");
	a_act_level: assert property (p_act_level) else $error("activate on driven pin");
	a_reselect: assert property (p_reselect) else $error("sensor not reselected");
	a_prog_len: assert property (p_prog_len) else $error("programming pulse length");
	a_prog_wait: assert property (p_prog_wait) else $error("programming delay wrong");
	a_prog_hold: assert property (p_prog_hold) else $error("lines moved in pulse");

	c_act: cover property ($fell(pgm_out_oe));
	c_prog: cover property ($fell(prog_lvl));
	c_deselect: cover property ($fell(dev_out_oe));
	c_reply: cover property (out_chg && dev_out_oe && dev_out_o);
endmodule : slp_link_assertions

// *** supply_line_sensor_programming_link_bench.sv ***
// self-checking bench: programmer and sensor joined over the link
`timescale 1ns/1ps
`include "slp_consts.svh"
module supply_line_sensor_programming_link_bench import slp_pkg::*;;
	localparam int SUP  = 40;
	localparam int OUT  = 60;
	localparam int SYNC = 200;
	localparam int TMO  = 400;
	localparam int TW   = 10;
	localparam int PROG = 100;
	logic         clk_sys   = 1'b0;
	logic         rst_n     = 1'b0;
	logic         nv_wipe   = 1'b1;
	logic         start     = 1'b0;
	logic         act_start = 1'b0;
	slp_cmd_type  cmd       = 3'h0;
	slp_addr_type addr      = 4'h0;
	slp_data_type wdata     = 14'h0000;
	logic [11:0]  adc_code  = 12'hD69;
	logic         selected, lock_applied, cmd_done, busy, done, ack_ok, rdata_ok, prog_bad;
	slp_data_type rdata;
	logic [11:0]  prog_voltage_code;
	int           failures  = 0;
	int           num_checks = 0;
	int           accepts    = 0;
	int unsigned  gaps[$];
	int unsigned  gap       = 0;
	logic         sup_q     = 1'b1;
	slp_data_type dv[2]     = '{14'h00A1, 14'h3FFF};
	slp_cmd_type  bad[3]    = '{3'h0, 3'h1, 3'h6};
	slp_cmd_type  ops[2]    = '{`SLP_CMD_ERASE, `SLP_CMD_PROG};
	logic [11:0]  codes[2]  = '{12'hD4E, 12'hD85};

	slp_link_if slp_link_if_inst ();
	slp_sensor #(.OUT_CYC(OUT), .SYNC_MAX(SYNC)) slp_sensor_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .link(slp_link_if_inst), .nv_wipe(nv_wipe), .selected(selected),
		.lock_applied(lock_applied), .cmd_done(cmd_done));
	slp_programmer #(.SUP_CYC(SUP), .ACK_TMO(TMO), .TW_CYC(TW), .PROG_CYC(PROG))
		slp_programmer_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(slp_link_if_inst),
		.start(start), .cmd(cmd), .addr(addr), .wdata(wdata), .act_start(act_start),
		.busy(busy), .done(done), .ack_ok(ack_ok), .rdata(rdata), .rdata_ok(rdata_ok),
		.adc_code(adc_code), .prog_voltage_code(prog_voltage_code), .prog_bad(prog_bad));
	slp_link_assertions #(.SUP_CYC(SUP), .OUT_CYC(OUT), .TW_CYC(TW), .PROG_CYC(PROG))
		slp_link_assertions_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.supply_lvl(slp_link_if_inst.supply_lvl), .prog_lvl(slp_link_if_inst.prog_lvl),
		.dev_out_o(slp_link_if_inst.dev_out_o), .dev_out_oe(slp_link_if_inst.dev_out_oe),
		.pgm_out_o(slp_link_if_inst.pgm_out_o), .pgm_out_oe(slp_link_if_inst.pgm_out_oe),
		.out_lvl(slp_link_if_inst.out_lvl));

	always #12.5 clk_sys = ~clk_sys;

	// gap lengths between supply line edges
	always @(posedge clk_sys)
	begin
		sup_q <= slp_link_if_inst.supply_lvl;
		if (slp_link_if_inst.supply_lvl !== sup_q)
		begin
			gaps.push_back(gap);
			gap <= 1;
		end
		else
			gap <= gap + 1;
	end

	// telegrams the sensor accepted
	always @(posedge clk_sys)
		if (cmd_done === 1'b1)
			accepts <= accepts + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		num_checks++;
		if (seen !== expd)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask : check

	task automatic conclude;
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	function automatic logic [24:0] frame(slp_cmd_type c, slp_addr_type a, slp_data_type d);
		return {1'b0, c, ($countones(~c) % 2) == 1, a, ($countones(~a) % 2) == 1, d,
			($countones(~d) % 2) == 0};
	endfunction : frame

	// decode n supply bits, left aligned
	task automatic check_wire(input logic [24:0] expd, input int n);
		logic [24:0] got;
		int          i;
		got = '0;
		i = 1;
		for (int k = 0; k < n && i < gaps.size(); k++)
		begin
			got[24 - k] = gaps[i] < SUP * 3 / 4;
			i = i + (got[24 - k] ? 2 : 1);
		end
		check(got, expd & ~(25'h1FFFFFF >> n));
	endtask : check_wire

	task automatic wait_done;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 8000)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check(done, 1'b1);
	endtask : wait_done

	task automatic send(input slp_cmd_type c, input slp_addr_type a, input slp_data_type d);
		repeat (4) @(posedge clk_sys);
		#1;
		gaps.delete();
		start = 1'b1;
		cmd = c;
		addr = a;
		wdata = d;
		@(posedge clk_sys);
		#1;
		start = 1'b0;
		check(busy, 1'b1);
		wait_done();
	endtask : send

	task automatic do_reset;
		rst_n = 1'b0;
		repeat (7) @(posedge clk_sys);
		#1;
		nv_wipe = 1'b0;
		@(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : do_reset

	initial
	begin
		repeat (80000) @(posedge clk_sys);
		failures++;
		conclude();
	end

	initial
	begin
		do_reset();
		check(selected, 1'b1);
		check(lock_applied, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			send(`SLP_CMD_WRITE, 4'h2 + 4'(i), dv[i]);
			check_wire(frame(`SLP_CMD_WRITE, 4'h2 + 4'(i), dv[i]), 25);
			check(ack_ok, 1'b1);
			send(`SLP_CMD_READ, 4'h2 + 4'(i), 14'h0000);
			check_wire(frame(`SLP_CMD_READ, 4'h2 + 4'(i), 14'h0000), 10);
			check(rdata, dv[i]);
			check(rdata_ok, 1'b1);
		end
		foreach (bad[i])
		begin
			send(bad[i], 4'h2, 14'h0000);
			check(ack_ok, 1'b0);
		end
		check(accepts, 32'h00000004);
		foreach (ops[i])
		begin
			adc_code = codes[i];
			send(ops[i], 4'h0, 14'h0000);
			check(ack_ok, 1'b1);
			check(prog_voltage_code, codes[i]);
			check(prog_bad, i == 1);
		end
		send(`SLP_CMD_WRITE, `SLP_ADDR_DEACT, 14'h0080);
		check(selected, 1'b0);
		check(slp_link_if_inst.out_lvl, 1'b0);
		send(`SLP_CMD_WRITE, 4'h2, 14'h0055);
		check(ack_ok, 1'b0);
		act_start = 1'b1;
		@(posedge clk_sys);
		#1;
		act_start = 1'b0;
		wait_done();
		repeat (4) @(posedge clk_sys);
		#1;
		check(selected, 1'b1);
		send(`SLP_CMD_READ, 4'h2, 14'h0000);
		check(rdata, 14'h00A1);
		adc_code = 12'hD69;
		send(`SLP_CMD_WRITE, `SLP_ADDR_LOCK, 14'h0001);
		check(ack_ok, 1'b1);
		foreach (ops[i])
		begin
			send(ops[i], 4'h0, 14'h0000);
			check(ack_ok, 1'b1);
		end
		send(`SLP_CMD_LOCK, `SLP_ADDR_LOCK, 14'h0000);
		check(ack_ok, 1'b1);
		check(lock_applied, 1'b0);
		do_reset();
		check(lock_applied, 1'b1);
		send(`SLP_CMD_READ, 4'h2, 14'h0000);
		check(rdata, 14'h00A1);
		send(`SLP_CMD_WRITE, 4'h2, 14'h0055);
		check(ack_ok, 1'b0);
		check(accepts, 32'h0000000D);
		conclude();
	end
endmodule : supply_line_sensor_programming_link_bench
